// ==== src/bca_pkg.sv ====
// package of constants for the battery capacity accounting block
package bca_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SAMPLE_PERIOD_S = 2;
  localparam longint unsigned SAMPLE_CYCLES = longint'(SAMPLE_PERIOD_S) * CLK_MHZ * 1000000;
  localparam int unsigned FAST_QUAL_S = 30;
  localparam int unsigned TRICKLE_VERIFY_MIN = 3;
  // counts in sample periods (one tick every 2 s)
  localparam logic [7:0] FAST_QUAL_TICKS = 8'(FAST_QUAL_S / SAMPLE_PERIOD_S);
  localparam logic [7:0] TRICKLE_TICKS = 8'(TRICKLE_VERIFY_MIN * 60 / SAMPLE_PERIOD_S);
  localparam int unsigned TEMP_MEAS_CYCLES = 16;
  // ----------------------------------------
  // filter thresholds in microvolts
  // ----------------------------------------
  localparam logic [15:0] FILTER_UNCAL_UV = 16'h012C;
  localparam logic [15:0] FILTER_CAL_UV = 16'h0064;
  // ----------------------------------------
  // percentages
  // ----------------------------------------
  localparam logic [7:0] PCT_80 = 8'h50;
  localparam logic [7:0] PCT_85 = 8'h55;
  localparam logic [7:0] PCT_75 = 8'h4B;
  localparam logic [7:0] PCT_10 = 8'h0A;
  localparam logic [7:0] PCT_100 = 8'h64;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // programmed capacity is scaled into counter units by this shift
  localparam int unsigned PFC_SHIFT = 8;
  // ----------------------------------------
  // charge phase states
  // ----------------------------------------
  typedef enum logic [2:0] {
    BCA_CHG_IDLE = 3'b000,
    BCA_CHG_QUAL = 3'b001,
    BCA_CHG_FAST = 3'b010,
    BCA_CHG_TRKL = 3'b011
  } bca_chg_t;
endpackage

// ==== src/bca_sampler.sv ====
// two-second sampling timer and thermistor bias control
`timescale 1ns/1ps
module bca_sampler
  import bca_pkg::*;
#(
  parameter longint unsigned PERIOD = SAMPLE_CYCLES
)(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  output logic tick_out,
  output logic temp_busy_out
);
  logic [31:0] cnt_reg;
  logic [4:0] tcnt_reg;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 32'h00000000;
      tick_out <= 1'b0;
    end
    else if (cnt_reg == 32'(PERIOD - 1))
    begin
      cnt_reg <= 32'h00000000;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick_out <= 1'b0;
    end
  end

  // the measurement window opens with each tick
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      tcnt_reg <= 5'h00;
    else if (tick_out)
      tcnt_reg <= 5'(TEMP_MEAS_CYCLES);
    else if (tcnt_reg != 5'h00)
      tcnt_reg <= tcnt_reg - 5'h01;
  end

  assign temp_busy_out = (tcnt_reg != 5'h00);
endmodule // bca_sampler

// ==== src/bca_learn.sv ====
// learned full capacity update with the 75 percent floor
`timescale 1ns/1ps
module bca_learn
  import bca_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic init_in,
  input wire logic [15:0] init_value_in,
  input wire logic update_in,
  input wire logic [15:0] discharge_count_in,
  output logic [15:0] learned_out
);
  logic [23:0] floor_w;
  assign floor_w = ({8'h00, learned_out} * {16'h0000, PCT_75}) / 24'd100;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      learned_out <= RST_ZERO;
    else if (init_in)
      learned_out <= init_value_in;
    else if (update_in)
    begin
      if ({8'h00, discharge_count_in} < floor_w)
        learned_out <= floor_w[15:0];
      else
        learned_out <= discharge_count_in;
    end
  end
endmodule // bca_learn

// ==== src/bca_top.sv ====
// capacity accounting core of the gas gauge
`timescale 1ns/1ps
module bca_top
  import bca_pkg::*;
#(
  parameter longint unsigned SAMPLE_PERIOD = SAMPLE_CYCLES
)(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic init_in,
  input wire logic [15:0] current_sense_input_in,
  input wire logic [15:0] thermistor_input_in,
  input wire logic [7:0] internal_temp_in,
  input wire logic [7:0] external_temp_in,
  input wire logic [7:0] self_discharge_in,
  input wire logic charge_pulse_in,
  input wire logic discharge_pulse_in,
  input wire logic self_discharge_pulse_in,
  input wire logic [15:0] charge_uv_in,
  input wire logic [15:0] fast_threshold_uv_in,
  input wire logic [15:0] trickle_threshold_uv_in,
  input wire logic [15:0] charge_current_uv_in,
  input wire logic edv_detect_in,
  input wire logic calibrated_in,
  input wire logic config_select_input_in,
  input wire logic [3:0] design_capacity_select_in,
  input wire logic [7:0] design_capacity_code_in,
  output logic [15:0] current_measurement_reg_out,
  output logic [15:0] thermistor_voltage_reg_out,
  output logic [7:0] temperature_reg_out,
  output logic thermistor_bias_ctl_out,
  output logic thermistor_bias_ctl_oe_out,
  output logic [7:0] programmed_full_capacity_out,
  output logic [3:0] counting_scale_out,
  output logic [15:0] available_capacity_counter_out,
  output logic [15:0] discharge_counter_out,
  output logic [15:0] learned_full_capacity_out,
  output logic valid_discharge_flag_out,
  output logic end_of_discharge_flag_out,
  output logic charging_status_flag_out,
  output logic fast_qualified_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] prod;
    prod = {8'h00, v} * {16'h0000, p};
    pct_of = 16'((prod / 24'd100));
  endfunction

  logic tick_w;
  logic temp_busy_w;
  logic ext_sel_reg;
  logic [15:0] learned_w;
  logic [15:0] pfc_counts_w;
  logic [15:0] lim80_w;
  logic [15:0] lim85_w;
  logic [15:0] lim10_w;
  logic [15:0] filt_w;
  logic chg_ok_w;
  logic dis_ok_w;
  logic sd_ok_w;
  logic inc_w;
  logic edv_set_w;
  logic trickle_done_w;
  logic vdq_set_w;
  logic valid_chg_w;
  logic lmd_update_w;
  bca_chg_t chg_reg;
  bca_chg_t chg_next;
  logic [7:0] tcnt_reg;
  logic [1:0] inc_cnt_reg;
  logic [15:0] sd_cnt_reg;
  logic chg_since_vdq_reg;
  logic qual_dis_reg;
  logic qual_now_w;

  // ----------------------------------------
  // sampling
  // ----------------------------------------
  bca_sampler #(
    .PERIOD(SAMPLE_PERIOD)
  ) u_sampler (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick_w),
    .temp_busy_out(temp_busy_w)
  );

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      current_measurement_reg_out <= RST_ZERO;
      thermistor_voltage_reg_out <= RST_ZERO;
      temperature_reg_out <= 8'h00;
    end
    else if (tick_w)
    begin
      current_measurement_reg_out <= current_sense_input_in;
      thermistor_voltage_reg_out <= thermistor_input_in;
      // one lsb per degree, signed two's complement
      temperature_reg_out <= ext_sel_reg ? external_temp_in : internal_temp_in;
    end
  end

  // pin released (high impedance) during measurement, pulled low otherwise
  assign thermistor_bias_ctl_out = 1'b0;
  assign thermistor_bias_ctl_oe_out = !temp_busy_w;

  // ----------------------------------------
  // configuration latch
  // ----------------------------------------
  // pins are read only at init so a drifting divider cannot change the scale mid-cycle
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ext_sel_reg <= 1'b0;
      programmed_full_capacity_out <= 8'h00;
      counting_scale_out <= 4'h0;
    end
    else if (init_in)
    begin
      ext_sel_reg <= config_select_input_in;
      programmed_full_capacity_out <= design_capacity_code_in;
      counting_scale_out <= design_capacity_select_in;
    end
  end

  assign pfc_counts_w = {programmed_full_capacity_out, 8'h00};
  assign lim80_w = pct_of(learned_w, PCT_80);
  assign lim85_w = pct_of(learned_w, PCT_85);
  assign lim10_w = pct_of(pfc_counts_w, PCT_10);

  // ----------------------------------------
  // digital filter
  // ----------------------------------------
  assign filt_w = calibrated_in ? FILTER_CAL_UV : FILTER_UNCAL_UV;
  assign chg_ok_w = charge_pulse_in && (charge_uv_in >= filt_w);
  assign dis_ok_w = discharge_pulse_in && (charge_uv_in >= filt_w);
  assign sd_ok_w = self_discharge_pulse_in;
  assign inc_w = chg_ok_w && (available_capacity_counter_out < learned_w);

  // ----------------------------------------
  // charge phase tracking
  // ----------------------------------------
  always_comb
  begin
    chg_next = chg_reg;
    case (chg_reg)
      BCA_CHG_IDLE:
        if (charge_current_uv_in > fast_threshold_uv_in)
          chg_next = BCA_CHG_QUAL;
      BCA_CHG_QUAL:
        if (charge_current_uv_in <= fast_threshold_uv_in)
          chg_next = BCA_CHG_IDLE;
        else if (tcnt_reg >= FAST_QUAL_TICKS)
          chg_next = BCA_CHG_FAST;
      BCA_CHG_FAST:
        if (charge_current_uv_in <= fast_threshold_uv_in)
          chg_next = BCA_CHG_TRKL;
      BCA_CHG_TRKL:
        if (charge_current_uv_in > fast_threshold_uv_in || charge_current_uv_in <= trickle_threshold_uv_in)
          chg_next = BCA_CHG_IDLE;
        else if (tcnt_reg >= TRICKLE_TICKS)
          chg_next = BCA_CHG_IDLE;
      default:
        chg_next = BCA_CHG_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in || !charging_status_flag_out)
      chg_reg <= BCA_CHG_IDLE;
    else if (tick_w)
      chg_reg <= chg_next;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      tcnt_reg <= 8'h00;
    else if (tick_w)
    begin
      if (chg_next != chg_reg)
        tcnt_reg <= 8'h00;
      else if (tcnt_reg != 8'hFF)
        tcnt_reg <= tcnt_reg + 8'h01;
    end
  end

  assign trickle_done_w = tick_w && (chg_reg == BCA_CHG_TRKL) && (chg_next == BCA_CHG_IDLE)
    && (tcnt_reg >= TRICKLE_TICKS);
  assign fast_qualified_out = (chg_reg == BCA_CHG_FAST) || (chg_reg == BCA_CHG_TRKL);

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      charging_status_flag_out <= 1'b0;
    else if (chg_ok_w)
      charging_status_flag_out <= 1'b1;
    else if (dis_ok_w)
      charging_status_flag_out <= 1'b0;
  end

  // ----------------------------------------
  // available capacity counter
  // ----------------------------------------
  assign edv_set_w = edv_detect_in && !end_of_discharge_flag_out && !charging_status_flag_out;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      available_capacity_counter_out <= RST_ZERO;
    else if (edv_set_w)
      available_capacity_counter_out <= RST_ZERO;
    else if (trickle_done_w && available_capacity_counter_out > lim80_w
      && available_capacity_counter_out <= lim85_w)
      available_capacity_counter_out <= lim85_w;
    else if (inc_w)
      available_capacity_counter_out <= available_capacity_counter_out + 16'h0001;
    else if ((dis_ok_w || sd_ok_w) && available_capacity_counter_out != RST_ZERO)
      available_capacity_counter_out <= available_capacity_counter_out - 16'h0001;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      end_of_discharge_flag_out <= 1'b0;
    else if (edv_set_w)
      end_of_discharge_flag_out <= 1'b1;
    else if (valid_chg_w)
      end_of_discharge_flag_out <= 1'b0;
  end

  // ----------------------------------------
  // valid charge and discharge qualification
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in || dis_ok_w)
      inc_cnt_reg <= 2'b00;
    else if (inc_w && inc_cnt_reg != 2'b10)
      inc_cnt_reg <= inc_cnt_reg + 2'b01;
  end
  // first increment of a charge makes it valid
  assign valid_chg_w = inc_w && (inc_cnt_reg == 2'b00);

  assign vdq_set_w = charging_status_flag_out && !valid_discharge_flag_out
    && ((trickle_done_w && available_capacity_counter_out > lim80_w)
    || (available_capacity_counter_out == learned_w));

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      valid_discharge_flag_out <= 1'b0;
    else if (vdq_set_w)
      valid_discharge_flag_out <= 1'b1;
    else if (lmd_update_w || (edv_set_w && !qual_now_w))
      valid_discharge_flag_out <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in || vdq_set_w)
      chg_since_vdq_reg <= 1'b0;
    else if (valid_chg_w && valid_discharge_flag_out && !end_of_discharge_flag_out && !charging_status_flag_out)
      chg_since_vdq_reg <= 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in || vdq_set_w)
      sd_cnt_reg <= RST_ZERO;
    else if (sd_ok_w && sd_cnt_reg != COUNT_MAX)
      sd_cnt_reg <= sd_cnt_reg + 16'h0001;
  end

  // judged at the empty point: temperature is a signed degree count
  assign qual_now_w = valid_discharge_flag_out && !chg_since_vdq_reg
    && (sd_cnt_reg <= lim10_w) && !temperature_reg_out[7];

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      qual_dis_reg <= 1'b0;
    else if (edv_set_w)
      qual_dis_reg <= qual_now_w;
    else if (lmd_update_w)
      qual_dis_reg <= 1'b0;
  end

  // taken on the valid charge itself: that same charge clears the empty flag
  assign lmd_update_w = valid_chg_w && end_of_discharge_flag_out && qual_dis_reg;

  // ----------------------------------------
  // discharge counter
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || init_in)
      discharge_counter_out <= RST_ZERO;
    else if (vdq_set_w)
      discharge_counter_out <= RST_ZERO;
    else if ((dis_ok_w || (sd_ok_w && available_capacity_counter_out != RST_ZERO))
      && discharge_counter_out != COUNT_MAX)
      discharge_counter_out <= discharge_counter_out + 16'h0001;
  end

  // ----------------------------------------
  // learned full capacity
  // ----------------------------------------
  bca_learn u_learn (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .init_in(init_in),
    .init_value_in({design_capacity_code_in, 8'h00}),
    .update_in(lmd_update_w),
    .discharge_count_in(discharge_counter_out),
    .learned_out(learned_w)
  );

  assign learned_full_capacity_out = learned_w;
endmodule // bca_top

// ==== tb/bca_properties.sv ====
// assertion checker bound to the capacity accounting core
`timescale 1ns/1ps
module bca_properties
  import bca_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic init_in,
  input wire logic charge_pulse_in,
  input wire logic discharge_pulse_in,
  input wire logic self_discharge_pulse_in,
  input wire logic [15:0] charge_uv_in,
  input wire logic edv_detect_in,
  input wire logic [7:0] design_capacity_code_in,
  input wire logic thermistor_bias_ctl_oe_out,
  input wire logic [7:0] programmed_full_capacity_out,
  input wire logic [15:0] available_capacity_counter_out,
  input wire logic [15:0] discharge_counter_out,
  input wire logic [15:0] learned_full_capacity_out,
  input wire logic fast_qualified_out
);
  // ------
  // shorthands
  // ------
  wire logic oe = thermistor_bias_ctl_oe_out;
  wire logic [15:0] av = available_capacity_counter_out;
  wire logic [15:0] lf = learned_full_capacity_out;
  // charge alone; the trickle lift may move the count, so fast phases are left out
  wire logic only_c = charge_pulse_in && !discharge_pulse_in && !self_discharge_pulse_in
    && !edv_detect_in && !init_in && !fast_qualified_out;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ------
  // assertions
  // ------
  a_bias_window: assert property ($fell(oe) |-> (!oe) [*8] ##1 (!oe) [*8] ##1 oe)
    else $error("bias release window wrong");
  a_init_latch: assert property (init_in |=> programmed_full_capacity_out == $past(design_capacity_code_in))
    else $error("capacity code not latched");
  a_init_clear: assert property (init_in |=> av == 16'h0000 && discharge_counter_out == 16'h0000)
    else $error("counters not cleared at init");
  a_init_learn: assert property (init_in ##1 !init_in |=> lf == {programmed_full_capacity_out, 8'h00})
    else $error("learned capacity not loaded");
  a_cfg_hold: assert property (!init_in |=> $stable(programmed_full_capacity_out))
    else $error("latched code moved");
  a_charge_up: assert property (only_c && charge_uv_in >= 16'h012C && av < lf |=> av == $past(av) + 16'h0001)
    else $error("charge did not count");
  a_full_stop: assert property (only_c && av == lf |=> av == $past(av))
    else $error("count passed learned capacity");
  a_filter_hold: assert property (only_c && charge_uv_in < 16'h0064 |=> $stable(av))
    else $error("filtered charge counted");
  a_empty_floor: assert property (discharge_pulse_in && !charge_pulse_in && av == 16'h0000 |=> av == 16'h0000)
    else $error("count went below zero");
  a_edv_clear: assert property (discharge_pulse_in && edv_detect_in && !charge_pulse_in |-> ##[1:2] av == 16'h0000)
    else $error("empty did not clear count");
  c_full: cover property (only_c && av == lf);
  c_meas: cover property ($fell(oe));
  c_fast: cover property ($rose(fast_qualified_out));
endmodule // bca_properties

bind bca_top bca_properties u_props (.mclk_in, .rst_n_in, .init_in, .charge_pulse_in, .discharge_pulse_in,
  .self_discharge_pulse_in, .charge_uv_in, .edv_detect_in, .design_capacity_code_in, .thermistor_bias_ctl_oe_out,
  .programmed_full_capacity_out, .available_capacity_counter_out, .discharge_counter_out,
  .learned_full_capacity_out, .fast_qualified_out);

// ==== tb/bca_cells.sv ====
// behavioural sense resistor, cells and thermistors feeding the core
`timescale 1ns/1ps
module bca_cells (
  input wire logic [15:0] amps_in,
  input wire logic [7:0] degc_in,
  output logic [15:0] sense_out,
  output logic [15:0] therm_out,
  output logic [7:0] int_temp_out,
  output logic [7:0] ext_temp_out
);
  assign sense_out = amps_in;
  assign therm_out = {8'h40, degc_in};
  // internal sensor reads three degrees low so a wrong source choice shows
  assign int_temp_out = degc_in - 8'h03;
  assign ext_temp_out = degc_in;
endmodule // bca_cells

// ==== tb/testbench.sv ====
// self-checking bench for the capacity accounting core
`timescale 1ns/1ps
module testbench;
  import bca_pkg::*;
  localparam int SP = 100;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic init_in = 1'b0;
  logic [15:0] current_sense_input_in, thermistor_input_in;
  logic [7:0] internal_temp_in, external_temp_in;
  logic [7:0] self_discharge_in = 8'h00;
  logic charge_pulse_in = 1'b0, discharge_pulse_in = 1'b0, self_discharge_pulse_in = 1'b0;
  logic [15:0] charge_uv_in = 16'h0190;
  logic [15:0] fast_threshold_uv_in = 16'h07D0;
  logic [15:0] trickle_threshold_uv_in = 16'h01F4;
  logic [15:0] charge_current_uv_in = 16'h0000;
  logic edv_detect_in = 1'b0, calibrated_in = 1'b0, config_select_input_in = 1'b1;
  logic [3:0] design_capacity_select_in = 4'h5;
  logic [7:0] design_capacity_code_in = 8'h02;
  logic [15:0] amps = 16'h1234;
  logic [7:0] degc = 8'h19;
  logic [15:0] current_measurement_reg_out, thermistor_voltage_reg_out;
  logic [7:0] temperature_reg_out, programmed_full_capacity_out;
  logic thermistor_bias_ctl_out, thermistor_bias_ctl_oe_out;
  logic [3:0] counting_scale_out;
  logic [15:0] available_capacity_counter_out, discharge_counter_out, learned_full_capacity_out;
  logic valid_discharge_flag_out, end_of_discharge_flag_out, charging_status_flag_out, fast_qualified_out;
  int n_errors = 0;
  int n_tests = 0;
  bca_cells u_cells (.amps_in(amps), .degc_in(degc), .sense_out(current_sense_input_in),
    .therm_out(thermistor_input_in), .int_temp_out(internal_temp_in), .ext_temp_out(external_temp_in));
  bca_top #(.SAMPLE_PERIOD(SP)) DUT (.mclk_in, .rst_n_in, .init_in, .current_sense_input_in,
    .thermistor_input_in, .internal_temp_in, .external_temp_in, .self_discharge_in, .charge_pulse_in,
    .discharge_pulse_in, .self_discharge_pulse_in, .charge_uv_in, .fast_threshold_uv_in,
    .trickle_threshold_uv_in, .charge_current_uv_in, .edv_detect_in, .calibrated_in,
    .config_select_input_in, .design_capacity_select_in, .design_capacity_code_in,
    .current_measurement_reg_out, .thermistor_voltage_reg_out, .temperature_reg_out,
    .thermistor_bias_ctl_out, .thermistor_bias_ctl_oe_out, .programmed_full_capacity_out,
    .counting_scale_out, .available_capacity_counter_out, .discharge_counter_out,
    .learned_full_capacity_out, .valid_discharge_flag_out, .end_of_discharge_flag_out,
    .charging_status_flag_out, .fast_qualified_out);
  always #4 mclk_in = ~mclk_in;
  // ------
  // tasks
  // ------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // mask bits: 0 charge, 1 discharge, 2 self-discharge; pulses run back to back
  task automatic hit(input logic [2:0] k, input int n);
    {self_discharge_pulse_in, discharge_pulse_in, charge_pulse_in} = k;
    step(n);
    {self_discharge_pulse_in, discharge_pulse_in, charge_pulse_in} = 3'b000;
    step(1);
  endtask
  // bounded wait for the bias release that follows each sample tick
  task automatic meas();
    int i;
    i = 0;
    while (thermistor_bias_ctl_oe_out !== 1'b0 && i < 3 * SP)
    begin
      step(1);
      i++;
    end
    step(1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ------
  // watchdog: tests need about 12200 cycles
  // ------
  initial
  begin
    repeat (30000) @(posedge mclk_in);
    n_errors++;
    end_of_test();
  end
  // ------
  // tests
  // ------
  initial
  begin
    step(16);
    chk(available_capacity_counter_out, 16'h0000);
    chk({8'h00, programmed_full_capacity_out}, 16'h0000);
    chk({15'h0000, thermistor_bias_ctl_oe_out}, 16'h0001);
    rst_n_in = 1'b1;
    step(1);
    init_in = 1'b1;
    step(1);
    init_in = 1'b0;
    design_capacity_code_in = 8'hFF;
    design_capacity_select_in = 4'hA;
    config_select_input_in = 1'b0;
    step(2);
    chk({8'h00, programmed_full_capacity_out}, 16'h0002);
    chk({12'h000, counting_scale_out}, 16'h0005);
    chk(learned_full_capacity_out, 16'h0200);
    chk({15'h0000, thermistor_bias_ctl_out}, 16'h0000);
    $display("test init done");
    meas();
    chk(current_measurement_reg_out, 16'h1234);
    chk(thermistor_voltage_reg_out, 16'h4019);
    chk({8'h00, temperature_reg_out}, 16'h0019);
    amps = 16'h0ABC;
    degc = 8'h1A;
    step(20);
    chk(current_measurement_reg_out, 16'h1234);
    meas();
    chk(current_measurement_reg_out, 16'h0ABC);
    chk({8'h00, temperature_reg_out}, 16'h001A);
    $display("test sample done");
    hit(3'b010, 2);
    chk(available_capacity_counter_out, 16'h0000);
    chk(discharge_counter_out, 16'h0002);
    hit(3'b100, 1);
    chk(discharge_counter_out, 16'h0002);
    charge_uv_in = 16'h00C8;
    hit(3'b001, 1);
    chk(available_capacity_counter_out, 16'h0000);
    calibrated_in = 1'b1;
    hit(3'b001, 1);
    chk(available_capacity_counter_out, 16'h0001);
    chk({15'h0000, charging_status_flag_out}, 16'h0001);
    charge_uv_in = 16'h0032;
    hit(3'b001, 1);
    chk(available_capacity_counter_out, 16'h0001);
    charge_uv_in = 16'h0190;
    hit(3'b001, 514);
    chk(available_capacity_counter_out, 16'h0200);
    chk({15'h0000, valid_discharge_flag_out}, 16'h0001);
    chk(discharge_counter_out, 16'h0000);
    $display("test count done");
    hit(3'b010, 3);
    hit(3'b100, 2);
    chk(available_capacity_counter_out, 16'h01FB);
    chk(discharge_counter_out, 16'h0005);
    hit(3'b010, 200);
    chk(available_capacity_counter_out, 16'h0133);
    edv_detect_in = 1'b1;
    hit(3'b010, 1);
    step(1);
    chk(available_capacity_counter_out, 16'h0000);
    chk({15'h0000, end_of_discharge_flag_out}, 16'h0001);
    chk({15'h0000, charging_status_flag_out}, 16'h0000);
    edv_detect_in = 1'b0;
    hit(3'b001, 1);
    step(2);
    chk(available_capacity_counter_out, 16'h0001);
    chk(learned_full_capacity_out, 16'h0180);
    $display("test learn done");
    hit(3'b001, 309);
    chk(available_capacity_counter_out, 16'h0136);
    charge_current_uv_in = 16'h0BB8;
    step(13 * SP);
    chk({15'h0000, fast_qualified_out}, 16'h0000);
    step(4 * SP);
    chk({15'h0000, fast_qualified_out}, 16'h0001);
    charge_current_uv_in = 16'h03E8;
    step(80 * SP);
    chk(available_capacity_counter_out, 16'h0136);
    step(12 * SP);
    chk(available_capacity_counter_out, 16'h0146);
    chk({15'h0000, valid_discharge_flag_out}, 16'h0001);
    $display("test trickle done");
    end_of_test();
  end
endmodule // testbench
